// File: logic/uart_fc_pkg.sv
// Constants shared by the serial port with frame checking and address match.
// Assumes a single 50 MHz clock and an 8-bit register port.
package uart_fc_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] ADDR_DATA_BUF    = 8'h99;
  localparam logic [7:0] ADDR_RATE_RELOAD = 8'h9A;
  localparam logic [7:0] ADDR_RATE_CTRL   = 8'h9B;
  localparam logic [7:0] ADDR_NODE_ADDR   = 8'hA9;
  localparam logic [7:0] ADDR_NODE_MASK   = 8'hB9;
  localparam logic [7:0] ADDR_TIMER2_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hF0;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'hF1;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SC_MODE0_BIT   = 7;  // Mode bit zero, or frame error flag
  localparam int SC_MODE1_BIT   = 6;
  localparam int SC_MPE_BIT     = 5;
  localparam int SC_RX_EN_BIT   = 4;
  localparam int SC_TX_NINTH    = 3;
  localparam int SC_RX_NINTH    = 2;
  localparam int SC_TX_DONE_BIT = 1;
  localparam int SC_RX_DONE_BIT = 0;
  localparam int PC_DOUBLE_BIT  = 7;
  localparam int PC_FE_EN_BIT   = 6;
  localparam int RC_RUN_BIT     = 4;
  localparam int RC_TX_GEN_BIT  = 3;
  localparam int RC_RX_GEN_BIT  = 2;
  localparam int T2_RX_SEL_BIT  = 5;
  localparam int T2_TX_SEL_BIT  = 4;
  localparam int IRQ_RX_BIT     = 0;
  localparam int IRQ_TX_BIT     = 1;
  localparam int IRQ_FE_BIT     = 2;
  localparam int IRQ_W          = 3;
  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [3:0] SAMPLE_LAST  = 4'hF;  // 16 ticks per bit
  localparam logic [3:0] SAMPLE_MID   = 4'h7;
  localparam logic [3:0] LAST_BIT_8   = 4'h7;
  localparam logic [3:0] LAST_BIT_9   = 4'h8;
  localparam logic [1:0] SHIFT_HALF   = 2'h2;  // Half of a six-cycle shift bit
  localparam logic [1:0] MODE_SHIFT   = 2'h0;
  localparam logic [1:0] MODE_UART8   = 2'h1;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_t;
endpackage : uart_fc_pkg

// File: logic/addr_match_if.sv
// Carries a received address and the node address bytes to the matcher.
// Assumes both ends sit in the same clock domain; the match is combinational.
`timescale 1ns/1ps
interface addr_match_if;
  logic [7:0] rx_addr;
  logic [7:0] node_addr;
  logic [7:0] node_mask;
  logic       match;
  modport matcher (input rx_addr, input node_addr, input node_mask, output match);
  modport user    (output rx_addr, output node_addr, output node_mask, input match);
endinterface : addr_match_if

// File: logic/address_matcher.sv
// Compares a received address against the given and broadcast addresses.
// Assumes the caller samples the result only when a frame completes.
`timescale 1ns/1ps
module address_matcher (
  addr_match_if.matcher am
);
  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire [7:0] bcast_care = am.node_addr | am.node_mask;
  // Mask zeros are don't-care bits of the given address
  wire given_hit = ((am.rx_addr ^ am.node_addr) & am.node_mask) == 8'h00;
  // Zeros of the OR are don't-care; every one must be received as one
  wire bcast_hit = (~am.rx_addr & bcast_care) == 8'h00;
  assign am.match = given_hit | bcast_hit;
endmodule : address_matcher

// File: logic/rate_generator.sv
// Internal bit-rate generator: an 8-bit counter reloaded on overflow.
// Assumes the reload value is held steady while the generator runs.
`timescale 1ns/1ps
module rate_generator (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [7:0] reload_i,
  output logic            tick_o
);
  logic [7:0] cnt_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Counts up to FF, then restarts from the reload value with a tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && (cnt_r == 8'hFF);
      if (!run_i) cnt_r <= reload_i;
      else if (cnt_r == 8'hFF) cnt_r <= reload_i;
      else cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : rate_generator

// File: logic/uart_frame_check_addr_match.sv
// Serial port with stop-bit checking, hardware address recognition and
// separate transmit and receive rate sources.
// Assumes timer overflow pulses arrive as one-cycle inputs on SYS_CLK_I.
//
// Overview of operation
// - Modes 1, 2, 3 are full duplex; in modes 1 and 3 each direction may run its own rate.
// - Stop-bit checking works in modes 1-3, only while frame_error_enable is set.
// - When checking, an invalid stop bit sets the frame error flag.
// - The frame error flag stays set until software clears it or reset.
// - With checking on, receive done rises at the stop bit, not last data bit.
// - Address recognition is active while multiproc_enable is set.
// - Recognition on: address frames raise receive done only on a match.
// - 8-bit mode: stop bit acts as ninth bit; needs match and valid stop.
// - multiproc_enable has no effect in the shift mode.
// - A node answers its given address or its broadcast address.
// - Given address: node address with mask zeros as don't-care.
// - Broadcast address is address OR mask, zeros being don't-care.
// - Reset clears node address and mask, so any address is accepted.
// - Transmit and receive rate sources are chosen independently.
// - Generator select wins; otherwise timer 2 select, else timer 1.
// - Bit 7 of serial control is the frame error flag while checking is on.
// - Transmit done: after 8th bit in shift mode, at stop start otherwise.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module uart_frame_check_addr_match
  import uart_fc_pkg::*;
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WR_DATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RD_DATA_O,
  input  wire logic       TIMER1_TICK_I,
  input  wire logic       TIMER2_TICK_I,
  input  wire logic       RXD_I,
  output logic            RXD_O,
  output logic            RXD_OE_O,
  output logic            TXD_O,
  output logic            IRQ_O
);
  import uart_fc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  // Two flops so the release is clean to the rest of the block
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic            sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
  logic            fe_en_r, dbl_r, run_r, tx_gen_r, rx_gen_r, tx_t2_r, rx_t2_r;
  logic [7:0]      node_r, mask_r, reload_r, rbuf_r;
  logic [IRQ_W-1:0] stat_r, imask_r;
  logic            brg_tick, m2_div_r, m0_clk_r;
  logic [1:0]      m0_cnt_r;
  tx_state_t       tx_st_r;
  rx_state_t       rx_st_r;
  logic [3:0]      tx_cnt_r, tx_idx_r, rx_cnt_r, rx_idx_r;
  logic [8:0]      tx_sh_r, rx_sh_r;
  logic            tx_line_r;

  addr_match_if am ();

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_pc   = WR_I && (ADDR_I == ADDR_POWER_CTRL);
  wire wr_sc   = WR_I && (ADDR_I == ADDR_SERIAL_CTRL);
  wire wr_buf  = WR_I && (ADDR_I == ADDR_DATA_BUF);
  wire wr_rl   = WR_I && (ADDR_I == ADDR_RATE_RELOAD);
  wire wr_rc   = WR_I && (ADDR_I == ADDR_RATE_CTRL);
  wire wr_na   = WR_I && (ADDR_I == ADDR_NODE_ADDR);
  wire wr_nm   = WR_I && (ADDR_I == ADDR_NODE_MASK);
  wire wr_t2   = WR_I && (ADDR_I == ADDR_TIMER2_CTRL);
  wire wr_ist  = WR_I && (ADDR_I == ADDR_IRQ_STATUS);
  wire wr_imk  = WR_I && (ADDR_I == ADDR_IRQ_MASK);
  wire [1:0] mode = {sm0_r, sm1_r};
  wire mode0   = (mode == MODE_SHIFT);
  wire mode1   = (mode == MODE_UART8);
  wire nine    = sm0_r;                    // Modes 2 and 3 carry a ninth bit
  wire mpe_eff = mpe_r && !mode0;

  // Bit 7 reads as the error flag while checking is on
  wire bit7_rd = fe_en_r ? fe_r : sm0_r;
  wire [7:0] sc_rd = {bit7_rd, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
  wire [7:0] rd_mux =
    (ADDR_I == ADDR_POWER_CTRL)  ? {dbl_r, fe_en_r, 6'h00} :
    (ADDR_I == ADDR_SERIAL_CTRL) ? sc_rd :
    (ADDR_I == ADDR_DATA_BUF)    ? rbuf_r :
    (ADDR_I == ADDR_RATE_RELOAD) ? reload_r :
    (ADDR_I == ADDR_RATE_CTRL)   ? {3'h0, run_r, tx_gen_r, rx_gen_r, 2'h0} :
    (ADDR_I == ADDR_NODE_ADDR)   ? node_r :
    (ADDR_I == ADDR_NODE_MASK)   ? mask_r :
    (ADDR_I == ADDR_TIMER2_CTRL) ? {2'h0, rx_t2_r, tx_t2_r, 4'h0} :
    (ADDR_I == ADDR_IRQ_STATUS)  ? {5'h00, stat_r} :
    (ADDR_I == ADDR_IRQ_MASK)    ? {5'h00, imask_r} : 8'h00;

  // ----------------------------------------------------------------
  // Rate sources
  // ----------------------------------------------------------------
  rate_generator u_rate_gen (
    .clk_i    (SYS_CLK_I),
    .rst_n_i  (rst_n),
    .run_i    (run_r),
    .reload_i (reload_r),
    .tick_o   (brg_tick)
  );

  // Each direction picks its own source; generator first, then timer 2
  wire tx_src = tx_gen_r ? brg_tick : (tx_t2_r ? TIMER2_TICK_I : TIMER1_TICK_I);
  wire rx_src = rx_gen_r ? brg_tick : (rx_t2_r ? TIMER2_TICK_I : TIMER1_TICK_I);
  // Mode 2 runs at clock/32, or clock/16 when doubled
  wire m2_tick = dbl_r | m2_div_r;
  wire tx_tick = (mode == 2'h2) ? m2_tick : tx_src;
  wire rx_tick = (mode == 2'h2) ? m2_tick : rx_src;
  wire half_tick = (m0_cnt_r == SHIFT_HALF);

  // Fixed dividers for the shift mode and mode 2
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      m2_div_r <= 1'b0;
      m0_cnt_r <= 2'h0;
    end else begin
      m2_div_r <= !m2_div_r;
      m0_cnt_r <= half_tick ? 2'h0 : m0_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shift mode clock
  // ----------------------------------------------------------------
  // Idles high; transmit data changes and receive data is taken on the rise
  wire m0_busy = mode0 && ((tx_st_r == TX_DATA) || (rx_st_r == RX_DATA));
  wire m0_rise = half_tick && m0_busy && !m0_clk_r;

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) m0_clk_r <= 1'b1;
    else if (!m0_busy) m0_clk_r <= 1'b1;
    else if (half_tick) m0_clk_r <= !m0_clk_r;
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  wire tx_bit_end = tx_tick && (tx_cnt_r == SAMPLE_LAST);
  wire [3:0] tx_last = nine ? LAST_BIT_9 : LAST_BIT_8;
  // A write while busy, or while a shift-mode receive owns the clock, is dropped
  wire tx_load = wr_buf && (tx_st_r == TX_IDLE) && !(mode0 && rx_st_r != RX_IDLE);
  wire tx_done_async = (tx_st_r == TX_DATA) && !mode0 && tx_bit_end && (tx_idx_r == tx_last);
  wire tx_done_m0 = (tx_st_r == TX_DATA) && mode0 && m0_rise && (tx_idx_r == LAST_BIT_8);
  wire tx_done_ev = tx_done_async | tx_done_m0;

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r   <= TX_IDLE;
      tx_cnt_r  <= 4'h0;
      tx_idx_r  <= 4'h0;
      tx_sh_r   <= 9'h000;
      tx_line_r <= 1'b1;
    end else begin
      if (tx_tick) tx_cnt_r <= tx_cnt_r + 4'h1;
      unique case (tx_st_r)
        TX_IDLE: begin
          if (tx_load) begin
            tx_sh_r  <= {tb8_r, WR_DATA_I};
            tx_idx_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            tx_st_r  <= mode0 ? TX_DATA : TX_START;
            tx_line_r <= mode0 ? WR_DATA_I[0] : 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_line_r <= tx_sh_r[0];
            tx_st_r   <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (mode0 ? m0_rise : tx_bit_end) begin
            if (tx_done_ev) begin
              tx_line_r <= 1'b1;
              tx_st_r   <= mode0 ? TX_IDLE : TX_STOP;
            end else begin
              tx_line_r <= tx_sh_r[1];
              tx_sh_r   <= {1'b0, tx_sh_r[8:1]};
              tx_idx_r  <= tx_idx_r + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_end) tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  wire rx_sample = rx_tick && (rx_cnt_r == SAMPLE_LAST);
  wire [3:0] rx_last = nine ? LAST_BIT_9 : LAST_BIT_8;
  wire rx_last_async = (rx_st_r == RX_DATA) && !mode0 && rx_sample && (rx_idx_r == rx_last);
  wire rx_stop_smp = (rx_st_r == RX_STOP) && rx_sample;
  wire rx_done_m0 = (rx_st_r == RX_DATA) && mode0 && m0_rise && (rx_idx_r == LAST_BIT_8);
  // Holding the decision for the stop bit lets it be checked first
  wire defer = fe_en_r || (mode1 && mpe_eff);
  wire decide = (rx_last_async && !defer) || (rx_stop_smp && defer);
  wire [8:0] cur_sh = (rx_st_r == RX_STOP) ? rx_sh_r : {RXD_I, rx_sh_r[8:1]};
  wire [7:0] rx_byte = nine ? cur_sh[7:0] : cur_sh[8:1];
  wire stop_val = (rx_st_r == RX_STOP) ? RXD_I : 1'b1;
  wire ninth_eff = nine ? cur_sh[8] : stop_val;
  // Zero ninth bit means data, dropped while filtering; one means address
  wire rx_accept = !ri_r && (!mpe_eff || (ninth_eff && am.match));
  wire rx_done_ev = (decide && rx_accept) || (rx_done_m0 && !ri_r);
  wire fe_ev = rx_stop_smp && fe_en_r && !RXD_I;

  assign am.rx_addr   = rx_byte;
  assign am.node_addr = node_r;
  assign am.node_mask = mask_r;

  address_matcher u_matcher (
    .am (am)
  );

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else begin
      if (rx_tick) rx_cnt_r <= rx_cnt_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_idx_r <= 4'h0;
          if (ren_r && mode0 && !ri_r && tx_st_r == TX_IDLE) begin
            rx_st_r <= RX_DATA;
          end else if (ren_r && !mode0 && rx_tick && !RXD_I) begin
            rx_cnt_r <= 4'h1;
            rx_st_r  <= RX_START;
          end
        end
        RX_START: begin
          // A start bit gone high by mid-bit was noise
          if (rx_tick && rx_cnt_r == SAMPLE_MID) begin
            rx_cnt_r <= 4'h0;
            rx_st_r  <= RXD_I ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (mode0 ? m0_rise : rx_sample) begin
            rx_sh_r  <= {RXD_I, rx_sh_r[8:1]};
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_done_m0) rx_st_r <= RX_IDLE;
            else if (rx_last_async) rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle
  wire ri_nxt = rx_done_ev | (wr_sc ? WR_DATA_I[SC_RX_DONE_BIT] : ri_r);
  wire ti_nxt = tx_done_ev | (wr_sc ? WR_DATA_I[SC_TX_DONE_BIT] : ti_r);
  wire fe_wr  = wr_sc && fe_en_r;
  wire fe_nxt = fe_ev | (fe_wr ? WR_DATA_I[SC_MODE0_BIT] : fe_r);
  wire [IRQ_W-1:0] ev = {fe_ev, tx_done_ev, rx_done_ev};
  wire [IRQ_W-1:0] stat_nxt = ev | (stat_r & ~(wr_ist ? WR_DATA_I[IRQ_W-1:0] : 3'h0));

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      {sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= RESET_BYTE;
      fe_r     <= 1'b0;
      fe_en_r  <= 1'b0;
      dbl_r    <= 1'b0;
      run_r    <= 1'b0;
      tx_gen_r <= 1'b0;
      rx_gen_r <= 1'b0;
      tx_t2_r  <= 1'b0;
      rx_t2_r  <= 1'b0;
      node_r   <= RESET_BYTE;
      mask_r   <= RESET_BYTE;
      reload_r <= RESET_BYTE;
      rbuf_r   <= RESET_BYTE;
      stat_r   <= 3'h0;
      imask_r  <= 3'h0;
    end else begin
      ri_r   <= ri_nxt;
      ti_r   <= ti_nxt;
      fe_r   <= fe_nxt;
      stat_r <= stat_nxt;
      if (wr_sc) begin
        if (!fe_en_r) sm0_r <= WR_DATA_I[SC_MODE0_BIT];
        sm1_r <= WR_DATA_I[SC_MODE1_BIT];
        mpe_r <= WR_DATA_I[SC_MPE_BIT];
        ren_r <= WR_DATA_I[SC_RX_EN_BIT];
        tb8_r <= WR_DATA_I[SC_TX_NINTH];
      end
      // Received ninth bit, or in 8-bit mode the stop bit if the decision waits for it, else one
      if (rx_done_ev) rb8_r <= ninth_eff;
      else if (wr_sc) rb8_r <= WR_DATA_I[SC_RX_NINTH];
      if (rx_done_ev) rbuf_r <= mode0 ? cur_sh[8:1] : rx_byte;
      if (wr_pc) begin
        dbl_r   <= WR_DATA_I[PC_DOUBLE_BIT];
        fe_en_r <= WR_DATA_I[PC_FE_EN_BIT];
      end
      if (wr_rc) begin
        run_r    <= WR_DATA_I[RC_RUN_BIT];
        tx_gen_r <= WR_DATA_I[RC_TX_GEN_BIT];
        rx_gen_r <= WR_DATA_I[RC_RX_GEN_BIT];
      end
      if (wr_t2) begin
        tx_t2_r <= WR_DATA_I[T2_TX_SEL_BIT];
        rx_t2_r <= WR_DATA_I[T2_RX_SEL_BIT];
      end
      if (wr_na) node_r <= WR_DATA_I;
      if (wr_nm) mask_r <= WR_DATA_I;
      if (wr_rl) reload_r <= WR_DATA_I;
      if (wr_imk) imask_r <= WR_DATA_I[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA_O <= 8'h00;
      TXD_O     <= 1'b1;
      RXD_O     <= 1'b1;
      RXD_OE_O  <= 1'b0;
      IRQ_O     <= 1'b0;
    end else begin
      RD_DATA_O <= RD_I ? rd_mux : 8'h00;
      TXD_O     <= mode0 ? m0_clk_r : tx_line_r;
      RXD_O     <= tx_line_r;
      RXD_OE_O  <= mode0 && (tx_st_r == TX_DATA);
      IRQ_O     <= |(stat_nxt & imask_r);
    end
  end
endmodule : uart_frame_check_addr_match

// File: tb/uart_fc_chk.sv
// Port-level checks for the serial port with address match.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module uart_fc_chk
  import uart_fc_pkg::*;
(
  input wire logic       SYS_CLK_I,
  input wire logic       RESET_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic       RXD_OE_O,
  input wire logic       TXD_O,
  input wire logic       IRQ_O
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  a_read_idle_zero: assert property (!$past(RD_I) |-> RD_DATA_O == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_read_zero: assert property (RD_I && ADDR_I == 8'h10 |=> RD_DATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_node_addr_rw: assert property ((WR_I && ADDR_I == ADDR_NODE_ADDR) ##1
    (RD_I && ADDR_I == ADDR_NODE_ADDR) |=> RD_DATA_O == $past(WR_DATA_I, 2))
    else $error("node address readback wrong");
  a_node_mask_rw: assert property ((WR_I && ADDR_I == ADDR_NODE_MASK) ##1
    (RD_I && ADDR_I == ADDR_NODE_MASK) |=> RD_DATA_O == $past(WR_DATA_I, 2))
    else $error("node mask readback wrong");
  // ----------------------------------------------------------------
  // Reset and interrupt
  // ----------------------------------------------------------------
  a_reset_quiet_out: assert property ($rose(RESET_N_I) |-> TXD_O && !RXD_OE_O && !IRQ_O)
    else $error("outputs not idle after reset");
  a_irq_mask_off: assert property
    (WR_I && ADDR_I == ADDR_IRQ_MASK && WR_DATA_I == 8'h00 |-> ##2 !IRQ_O)
    else $error("interrupt stays up with mask cleared");
  a_irq_clear_drop: assert property
    (WR_I && ADDR_I == ADDR_IRQ_STATUS && WR_DATA_I == 8'h07 |-> ##2 !IRQ_O)
    else $error("interrupt stays up after clearing status");
  a_status_tx_clear: assert property ((WR_I && ADDR_I == ADDR_IRQ_STATUS && WR_DATA_I[1]) ##1
    (RD_I && ADDR_I == ADDR_IRQ_STATUS) |=> !RD_DATA_O[1])
    else $error("transmit status bit not cleared");
  c_mask_write: cover property (WR_I && ADDR_I == ADDR_NODE_MASK);
  c_irq_rise: cover property ($rose(IRQ_O));
  c_tx_start: cover property ($fell(TXD_O));
endmodule : uart_fc_chk

bind uart_frame_check_addr_match uart_fc_chk chk_u (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .RXD_OE_O(RXD_OE_O), .TXD_O(TXD_O),
  .IRQ_O(IRQ_O));

// File: tb/serial_node.sv
// Remote node that sends asynchronous frames onto the receive line.
// Assumes a bit time of 32 clocks: 16 ticks, one every second clock.
`timescale 1ns/1ps
module serial_node #(
  parameter int BIT_CYC = 32
) (
  input  wire logic clk_i,
  output logic      line_o
);
  // Line rests high between frames, like a pulled-up wire
  initial line_o = 1'b1;
  // Start bit, 8 data bits LSB first, stop bit of chosen level
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
endmodule : serial_node

// File: tb/test_uart_frame_check_addr_match.sv
// Self-checking bench for the serial port with address match.
// Assumes the package constants and a partner node at 32 clocks per bit.
`timescale 1ns/1ps
module test_uart_frame_check_addr_match;
  import uart_fc_pkg::*;
  logic       SYS_CLK_I, RESET_N_I, WR_I, RD_I, TIMER1_TICK_I, TIMER2_TICK_I, RXD_I;
  logic       RXD_O, RXD_OE_O, TXD_O, IRQ_O, t1_en, t2_en;
  logic       div_r = 1'b0;
  logic [7:0] ADDR_I, WR_DATA_I, RD_DATA_O, v, a;
  logic [8:0] f;
  int         err_count, check_count, seed, n;
  logic [7:0] exp_q[$];
  logic [7:0] tbl[6] = '{8'h54, 8'h57, 8'h50, 8'hFF, 8'hFE, 8'h12};
  uart_frame_check_addr_match dut_u (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
    .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
    .TIMER1_TICK_I(TIMER1_TICK_I), .TIMER2_TICK_I(TIMER2_TICK_I), .RXD_I(RXD_I),
    .RXD_O(RXD_O), .RXD_OE_O(RXD_OE_O), .TXD_O(TXD_O), .IRQ_O(IRQ_O));
  serial_node node_u (.clk_i(SYS_CLK_I), .line_o(RXD_I));
  // 50 MHz clock
  initial begin
    SYS_CLK_I = 1'b0;
    forever #10 SYS_CLK_I = ~SYS_CLK_I;
  end
  // Rate ticks every second clock; sources gated so a wrong pick loses the frame
  always @(posedge SYS_CLK_I) begin
    div_r <= ~div_r;
    TIMER1_TICK_I <= t1_en & div_r;
    TIMER2_TICK_I <= t2_en & div_r;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Strobe drops at the taking edge; #1 keeps the next request out of that step
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    ADDR_I <= ad;
    WR_DATA_I <= d;
    WR_I <= 1'b1;
    @(posedge SYS_CLK_I);
    WR_I <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    ADDR_I <= ad;
    RD_I <= 1'b1;
    @(posedge SYS_CLK_I);
    RD_I <= 1'b0;
    #1 d = RD_DATA_O;
  endtask : rd
  // One frame in, then receive done and data against the model
  task automatic rxf(input logic [7:0] d, input logic stp, input logic ok, input logic [7:0] sc);
    node_u.send(d, stp);
    repeat (4) @(posedge SYS_CLK_I);
    rd(ADDR_SERIAL_CTRL, v);
    chk("rx done", {7'h00, v[0]}, {7'h00, ok});
    if (ok) begin
      exp_q.push_back(d);
      rd(ADDR_DATA_BUF, v);
      chk("rx data", v, exp_q.pop_front());
    end
    if (!stp) repeat (320) @(posedge SYS_CLK_I);
    wr(ADDR_SERIAL_CTRL, sc);
  endtask : rxf
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Hang guard
  initial begin
    #1600000;
    err_count++;
    finish_test();
  end
  initial begin
    {WR_I, RD_I, t2_en} = '0;
    {ADDR_I, WR_DATA_I} = '0;
    t1_en = 1'b1;
    seed = 6813;
    RESET_N_I = 1'b0;
    repeat (5) @(posedge SYS_CLK_I);
    RESET_N_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    rd(ADDR_NODE_ADDR, v); chk("node addr", v, 8'h00);
    rd(ADDR_NODE_MASK, v); chk("node mask", v, 8'h00);
    rd(8'h10, v); chk("unmapped", v, 8'h00);
    $display("reset test done");
    // Stop-bit checking: bad stop sets the flag, good frame leaves it
    wr(ADDR_SERIAL_CTRL, 8'h50);
    wr(ADDR_POWER_CTRL, 8'h40);
    rxf(8'hA5, 1'b0, 1'b1, 8'hD0);
    rd(ADDR_SERIAL_CTRL, v); chk("frame err", v & 8'h81, 8'h80);
    rxf(8'h3C, 1'b1, 1'b1, 8'hD0);
    rd(ADDR_SERIAL_CTRL, v); chk("err sticky", v & 8'h80, 8'h80);
    wr(ADDR_POWER_CTRL, 8'h00);
    rd(ADDR_SERIAL_CTRL, v); chk("err hidden", v & 8'h80, 8'h00);
    wr(ADDR_POWER_CTRL, 8'h40);
    rd(ADDR_SERIAL_CTRL, v); chk("err shown", v & 8'h80, 8'h80);
    wr(ADDR_SERIAL_CTRL, 8'h50);
    rd(ADDR_SERIAL_CTRL, v); chk("err clear", v & 8'h80, 8'h00);
    wr(ADDR_POWER_CTRL, 8'h00);
    $display("frame error test done");
    // Address recognition in the 8-bit mode
    wr(ADDR_SERIAL_CTRL, 8'h70);
    a = 8'($random(seed));
    rxf(a, 1'b1, 1'b1, 8'h70);
    wr(ADDR_NODE_ADDR, 8'h56);
    rd(ADDR_NODE_ADDR, v);
    wr(ADDR_NODE_MASK, 8'hFC);
    rd(ADDR_NODE_MASK, v);
    for (int i = 0; i < 12; i++) begin
      a = (i < 6) ? tbl[i] : 8'($random(seed));
      rxf(a, 1'b1, hit(a, 8'h56, 8'hFC), 8'h70);
    end
    wr(ADDR_NODE_MASK, 8'hFF);
    rxf(8'h57, 1'b1, 1'b0, 8'h70);
    rxf(8'h55, 1'b0, 1'b0, 8'h70);
    $display("address test done");
    // Receive rate source: timer 1, timer 2, internal generator
    wr(ADDR_SERIAL_CTRL, 8'h50);
    wr(ADDR_RATE_RELOAD, 8'hFE);
    for (int k = 0; k < 3; k++) begin
      t1_en <= (k == 0);
      t2_en <= (k == 1);
      wr(ADDR_TIMER2_CTRL, (k == 1) ? 8'h20 : 8'h00);
      wr(ADDR_RATE_CTRL, (k == 2) ? 8'h14 : 8'h00);
      rxf(8'($random(seed)), 1'b1, 1'b1, 8'h50);
    end
    $display("rate source test done");
    // Transmit on timer 1 while receive stays on the generator
    t1_en <= 1'b1;
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_DATA_BUF, 8'h96);
    repeat (15) @(posedge SYS_CLK_I);
    for (int i = 0; i < 9; i++) begin
      repeat (i > 0 ? 32 : 1) @(posedge SYS_CLK_I);
      @(negedge SYS_CLK_I) f[i] = TXD_O;
    end
    chk("tx frame", f[8:1], 8'h96);
    chk("tx start", {7'h00, f[0]}, 8'h00);
    chk("tx early", {7'h00, IRQ_O}, 8'h00);
    for (n = 0; n < 64 && IRQ_O !== 1'b1; n++) @(negedge SYS_CLK_I);
    @(negedge SYS_CLK_I) chk("tx done", {6'h00, IRQ_O, TXD_O}, 8'h03);
    rd(ADDR_IRQ_STATUS, v); chk("irq status", v & 8'h02, 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h07);
    rd(ADDR_IRQ_STATUS, v); chk("irq cleared", v & 8'h02, 8'h00);
    chk("irq low", {7'h00, IRQ_O}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    $display("transmit test done");
    finish_test();
  end
  function automatic logic hit(input logic [7:0] x, input logic [7:0] na, input logic [7:0] nm);
    return (((x ^ na) & nm) == 8'h00) || ((x & (na | nm)) == (na | nm));
  endfunction : hit
endmodule : test_uart_frame_check_addr_match
